// *** core/protect_pkg.sv ***
// Shared constants and types for the battery protector control ends
package protect_pkg;
  localparam int CELL_COUNT = 10;
  localparam int CLK_MHZ = 250;
  // Host must wait this long before repeating a refused latch clear
  localparam int CLEAR_RETRY_MS = 1;
  localparam int CLEAR_RETRY_CYCLES = CLEAR_RETRY_MS * CLK_MHZ * 1000;
  // Host reset hold time after rail activation, in microseconds
  localparam int RESET_HOLD_US = 100;
  localparam int RESET_HOLD_CYCLES = RESET_HOLD_US * CLK_MHZ;
  localparam logic [7:0] MEM_UNLOCK_CODE = 8'he2;
  // APB register byte offsets of the host controller
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_BYPASS = 8'h04;
  localparam logic [7:0] REG_MEMDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  // Control register field positions
  localparam int CTL_HOSTMODE = 0;
  localparam int CTL_SHUTDOWN = 1;
  localparam int CTL_CLEAR = 2;
  localparam int CTL_BIAS = 3;
  localparam int CTL_SPARE = 4;
  localparam int CTL_CHG = 5;
  localparam int CTL_DSG = 6;
  localparam int CTL_ZVC = 7;
  localparam int CTL_MEMPULSE = 8;
  localparam int CTL_STATUSREAD = 9;
  localparam logic [31:0] CONTROL_RESET = 32'h00000000;
  typedef enum {PWR_NORMAL, PWR_DRAIN, PWR_OFF} power_state_t;
  typedef enum {RST_HOLD, RST_COUNT, RST_RELEASED} reset_state_t;
endpackage

// *** core/protect_if.sv ***
// Link between the protector device logic and its host controller
`timescale 1ns/10ps
interface protect_if;
  import protect_pkg::*;
  logic hostMode;
  logic shutdownRequest;
  logic latchClear;
  logic biasEnable;
  logic spareEnable;
  logic chargeEnable;
  logic dischargeEnable;
  logic zeroVoltCharge;
  logic [CELL_COUNT-1:0] bypassSelect;
  logic statusRead;
  logic [7:0] memControl;
  logic memPulse;
  logic [7:0] status;
  logic faultAlertN;
  logic hostResetN;
  modport device (input hostMode, shutdownRequest, latchClear, biasEnable, spareEnable, chargeEnable,
    dischargeEnable, zeroVoltCharge, bypassSelect, statusRead, memControl, memPulse,
    output status, faultAlertN, hostResetN);
  modport host (output hostMode, shutdownRequest, latchClear, biasEnable, spareEnable, chargeEnable,
    dischargeEnable, zeroVoltCharge, bypassSelect, statusRead, memControl, memPulse,
    input status, faultAlertN, hostResetN);
endinterface

// *** core/bypass_select.sv ***
// Chooses the cells to bypass, never two neighbours at once
`timescale 1ns/10ps
module bypass_select
  import protect_pkg::*;
(
  input wire logic [CELL_COUNT-1:0] request,
  input wire logic [CELL_COUNT-1:0] previous,
  output logic [CELL_COUNT-1:0] grant
);
  // Padded by one cell so the neighbour tests never index past either end
  logic [CELL_COUNT:0] pick;
  logic [CELL_COUNT:0] keptBelow;

  assign keptBelow = {request & previous, 1'b0};
  assign grant = pick[CELL_COUNT-1:0];

  // Cells already served keep priority so a started cell finishes first
  always_comb begin
    pick = {1'b0, request & previous};
    for (int i = CELL_COUNT - 1; i >= 0; i--) begin
      if (request[i] && !pick[i] && !pick[i + 1] && !keptBelow[i]) begin
        pick[i] = 1'b1;
      end
    end
  end
endmodule // bypass_select

// *** core/protect_device.sv ***
// Device end: balancing, protection, alert, host reset and power sequencing
//
// Design decisions made outside this module: the register offsets (protect_pkg) and the APB register port (protect_host).
`timescale 1ns/10ps

// How it works
// - Host mode bypasses cells per select bits
// - Stand-alone overvoltage stops charge, bypasses that cell
// - Bypass until hysteresis point, then recharge
// - Balancing ends when overvoltage protection releases
// - Never bypass two adjacent cells together
// - Bypass off while cells are sampled
// - Thermistor bias only when enabled, off at reset
// - Low temperature input trips both FETs, flags
// - Spare output follows enable, off at reset
// - Zero-volt charge drives precharge via spare output (here only in stand-alone mode, with a low cell)
// - Alert low whenever any fault detected
// - Stand-alone alert releases when faults clear
// - Host mode latches faults until clear toggle
// - After unlatch FETs follow host; read releases alert
// - Clear toggle ignored during voltage faults; retry later
// - Host reset held low after rail activation
// - Host reset low on low supply or bad rail
// - Memory commit needs unlock code then pulse
// - Host shutdown: discharge off, wait zero pack
// - Stand-alone undervoltage: discharge off, then shutdown
// - Shutdown turns every output off
// - Startup comparator leaves shutdown
module protect_device
  import protect_pkg::*;
#(
  parameter int RESET_HOLD = RESET_HOLD_CYCLES
)
(
  input wire logic mclk,
  input wire logic reset,
  protect_if.device link,
  input wire logic [CELL_COUNT-1:0] cellHigh,
  input wire logic [CELL_COUNT-1:0] cellRecovered,
  input wire logic [CELL_COUNT-1:0] cellLow,
  input wire logic sampling,
  input wire logic overloadTrip,
  input wire logic shortTrip,
  input wire logic tempBelowRef,
  input wire logic supplyLow,
  input wire logic railGood,
  input wire logic packZero,
  input wire logic startupDetect,
  output logic [CELL_COUNT-1:0] bypassCell,
  output logic chargeFetOn,
  output logic dischargeFetOn,
  output logic thermistorBiasOut,
  output logic spareOdOut,
  output logic spareOdOe,
  output logic memProgSupply,
  output logic memCommit
);
  power_state_t power_reg, power_next;
  reset_state_t rst_reg, rst_next;
  logic [CELL_COUNT-1:0] balance_reg, balance_next;
  logic [CELL_COUNT-1:0] bypass_next;
  logic [CELL_COUNT-1:0] bypassRequest;
  logic [CELL_COUNT-1:0] autoGrant;
  logic [3:0] latched_reg, latched_next;
  logic clearArmed_reg;
  logic alertHold_reg, alertHold_next;
  logic alert_next;
  logic [31:0] rstCount_reg;
  logic overTemp;
  logic clearDone;
  logic [3:0] liveFaults;
  logic anyFault;
  logic voltageFault;
  logic running;
  logic chg_next, dsg_next, spare_next;
  logic unlocked;

  assign running = power_reg != PWR_OFF;
  assign overTemp = tempBelowRef;
  assign liveFaults = {|cellLow, |cellHigh, overloadTrip, shortTrip};
  assign voltageFault = |cellHigh || |cellLow;
  assign anyFault = |liveFaults || overTemp;
  assign clearDone = clearArmed_reg && !link.latchClear && !voltageFault;

  // ----------------------------------------
  // Balancing
  // ----------------------------------------
  // Keep a cell bypassed until it reaches the hysteresis point
  assign balance_next = (balance_reg & ~cellRecovered) | cellHigh;

  // Host selections pass through the same neighbour filter as automatic ones
  assign bypassRequest = link.hostMode ? link.bypassSelect : balance_next;

  bypass_select u_select (
    .request(bypassRequest),
    .previous(bypassCell),
    .grant(autoGrant)
  );

  // Sampling overrides every selection so the monitor never reads a loaded cell
  assign bypass_next = (!running || sampling) ? '0 : autoGrant;

  // ----------------------------------------
  // Faults and alert
  // ----------------------------------------
  assign latched_next = clearDone ? liveFaults : (latched_reg | liveFaults);
  // Alert stays low after unlatch until the host reads status
  assign alertHold_next = link.hostMode && ((anyFault || |latched_reg) || (alertHold_reg && !link.statusRead));
  assign alert_next = link.hostMode ? !alertHold_next : !anyFault;

  assign chg_next = running && !overTemp && !(|cellHigh) && !(|liveFaults[1:0]) &&
    (link.hostMode ? (link.chargeEnable && latched_reg == 4'h0) : 1'b1);
  // Next power state, so discharge drops on the same edge that takes the request
  assign dsg_next = running && power_next == PWR_NORMAL && !overTemp && !(|liveFaults[1:0]) && !(|cellLow) &&
    (link.hostMode ? (link.dischargeEnable && latched_reg == 4'h0) : 1'b1);
  assign spare_next = running && (link.spareEnable || (!link.hostMode && link.zeroVoltCharge && |cellLow));

  // ----------------------------------------
  // Power sequencing
  // ----------------------------------------
  always_comb begin
    power_next = power_reg;
    unique case (power_reg)
      PWR_NORMAL: begin
        if ((link.hostMode && link.shutdownRequest) || (!link.hostMode && |cellLow)) begin
          power_next = PWR_DRAIN;
        end
      end
      PWR_DRAIN: begin
        if (packZero) begin
          power_next = PWR_OFF;
        end
      end
      PWR_OFF: begin
        if (startupDetect) begin
          power_next = PWR_NORMAL;
        end
      end
    endcase
  end

  always_comb begin
    rst_next = rst_reg;
    unique case (rst_reg)
      RST_HOLD: begin
        if (running && railGood && !supplyLow) begin
          rst_next = RST_COUNT;
        end
      end
      RST_COUNT: begin
        if (!running || !railGood || supplyLow) begin
          rst_next = RST_HOLD;
        end else if (rstCount_reg >= 32'(RESET_HOLD - 1)) begin
          rst_next = RST_RELEASED;
        end
      end
      RST_RELEASED: begin
        if (!running || !railGood || supplyLow) begin
          rst_next = RST_HOLD;
        end
      end
    endcase
  end

  // Commit pulses pass only while the unlock code stays written
  assign unlocked = link.memControl == MEM_UNLOCK_CODE;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      power_reg <= PWR_NORMAL;
      rst_reg <= RST_HOLD;
      rstCount_reg <= '0;
      balance_reg <= '0;
      latched_reg <= '0;
      clearArmed_reg <= 1'b0;
      alertHold_reg <= 1'b0;
      bypassCell <= '0;
      chargeFetOn <= 1'b0;
      dischargeFetOn <= 1'b0;
      thermistorBiasOut <= 1'b0;
      spareOdOut <= 1'b0;
      spareOdOe <= 1'b1;
      memProgSupply <= 1'b0;
      memCommit <= 1'b0;
      link.status <= '0;
      link.faultAlertN <= 1'b1;
      link.hostResetN <= 1'b0;
    end else begin
      power_reg <= power_next;
      rst_reg <= rst_next;
      rstCount_reg <= (rst_reg == RST_COUNT) ? rstCount_reg + 32'h1 : '0;
      balance_reg <= running && !link.hostMode ? balance_next : '0;
      latched_reg <= link.hostMode ? latched_next : '0;
      // Arm on a written one; a refused clear must be toggled again
      clearArmed_reg <= link.latchClear ? 1'b1 : 1'b0;
      alertHold_reg <= alertHold_next;
      bypassCell <= bypass_next;
      chargeFetOn <= chg_next;
      dischargeFetOn <= dsg_next;
      thermistorBiasOut <= running && link.biasEnable;
      spareOdOut <= 1'b0;
      spareOdOe <= !spare_next;
      memProgSupply <= running && unlocked;
      memCommit <= running && unlocked && link.memPulse;
      link.status <= running ? {chg_next, dsg_next, railGood, overTemp,
        link.hostMode ? latched_next : liveFaults} : 8'h00;
      link.faultAlertN <= running ? alert_next : 1'b1;
      link.hostResetN <= rst_next == RST_RELEASED;
    end
  end
endmodule // protect_device

// *** core/protect_host.sv ***
// Host end: APB registers that drive the protector link
`timescale 1ns/10ps
module protect_host
  import protect_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  protect_if.host link
);
  logic [31:0] control_reg;
  logic [CELL_COUNT-1:0] bypass_reg;
  logic [7:0] memData_reg;
  logic access, wrEn, rdStatus, known;

  assign access = psel && penable;
  assign wrEn = access && pwrite;
  assign rdStatus = access && !pwrite && paddr == REG_STATUS;
  assign known = paddr == REG_CONTROL || paddr == REG_BYPASS || paddr == REG_MEMDATA || paddr == REG_STATUS;

  // ----------------------------------------
  // Register access
  // ----------------------------------------
  // Software performs the clear toggle and the 1 ms retry itself
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      control_reg <= CONTROL_RESET;
      bypass_reg <= '0;
      memData_reg <= '0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !known;
      if (wrEn && paddr == REG_CONTROL) begin
        control_reg <= pwdata;
      end
      if (wrEn && paddr == REG_BYPASS) begin
        bypass_reg <= pwdata[CELL_COUNT-1:0];
      end
      if (wrEn && paddr == REG_MEMDATA) begin
        memData_reg <= pwdata[7:0];
      end
      unique case (paddr)
        REG_CONTROL: prdata <= control_reg;
        REG_BYPASS: prdata <= {22'h0, bypass_reg};
        REG_MEMDATA: prdata <= {24'h0, memData_reg};
        REG_STATUS: prdata <= {22'h0, link.hostResetN, link.faultAlertN, link.status};
        default: prdata <= '0;
      endcase
    end
  end

  assign link.hostMode = control_reg[CTL_HOSTMODE];
  assign link.shutdownRequest = control_reg[CTL_SHUTDOWN];
  assign link.latchClear = control_reg[CTL_CLEAR];
  assign link.biasEnable = control_reg[CTL_BIAS];
  assign link.spareEnable = control_reg[CTL_SPARE];
  assign link.chargeEnable = control_reg[CTL_CHG];
  assign link.dischargeEnable = control_reg[CTL_DSG];
  assign link.zeroVoltCharge = control_reg[CTL_ZVC];
  assign link.memPulse = control_reg[CTL_MEMPULSE];
  assign link.bypassSelect = bypass_reg;
  assign link.memControl = memData_reg;
  assign link.statusRead = rdStatus;
endmodule // protect_host

// *** verif/protect_chk.sv ***
// Concurrent checks on the protector link and device pins
`timescale 1ns/10ps
module protect_chk
  import protect_pkg::*;
#(
  parameter int RESET_HOLD = RESET_HOLD_CYCLES
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic hostMode,
  input wire logic shutdownRequest,
  input wire logic biasEnable,
  input wire logic spareEnable,
  input wire logic zeroVoltCharge,
  input wire logic [CELL_COUNT-1:0] bypassSelect,
  input wire logic faultAlertN,
  input wire logic hostResetN,
  input wire logic [CELL_COUNT-1:0] bypassCell,
  input wire logic chargeFetOn,
  input wire logic dischargeFetOn,
  input wire logic thermistorBiasOut,
  input wire logic spareOdOe,
  input wire logic sampling,
  input wire logic overloadTrip,
  input wire logic shortTrip,
  input wire logic tempBelowRef,
  input wire logic supplyLow,
  input wire logic railGood
);
  // Saturating count of healthy supply cycles, bounded to keep it small
  int goodRun;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      goodRun <= 0;
    end else if (!railGood || supplyLow) begin
      goodRun <= 0;
    end else if (goodRun < RESET_HOLD + 4) begin
      goodRun <= goodRun + 1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  chk_no_adjacent: assert property ((bypassCell & (bypassCell >> 1)) == '0)
    else $error("adjacent cells bypassed");
  chk_host_bypass: assert property (hostMode ##1 hostMode |=> (bypassCell & ~$past(bypassSelect)) == '0)
    else $error("unselected cell bypassed");
  chk_sample_off: assert property (sampling |=> bypassCell == '0)
    else $error("bypass on while sampling");
  chk_bias_off: assert property (!biasEnable |=> !thermistorBiasOut)
    else $error("bias driven while disabled");
  chk_temp_trip: assert property (tempBelowRef |=> !chargeFetOn && !dischargeFetOn)
    else $error("fets on at low temperature input");
  chk_spare_idle: assert property (!spareEnable && !zeroVoltCharge |=> spareOdOe)
    else $error("spare output active while disabled");
  chk_alert_low: assert property ((overloadTrip || shortTrip) |=> !faultAlertN)
    else $error("alert not raised on fault");
  chk_reset_hold: assert property ($rose(hostResetN) |-> goodRun >= RESET_HOLD - 1)
    else $error("host reset released early");
  chk_reset_drop: assert property ((!railGood || supplyLow) |=> !hostResetN)
    else $error("host reset high on bad supply");
  chk_power_down_request_dsg: assert property (hostMode && $rose(shutdownRequest) |=> !dischargeFetOn)
    else $error("discharge still on after shutdown");
endmodule // protect_chk

// *** verif/testbench.sv ***
// Self-checking bench joining host and device ends
`timescale 1ns/10ps
module testbench;
  import protect_pkg::*;
  logic mclk, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] cellHigh, cellRecovered, cellLow, bypassCell, b;
  logic sampling, overloadTrip, shortTrip, tempBelowRef, supplyLow, railGood, packZero, startupDetect;
  logic chargeFetOn, dischargeFetOn, thermistorBiasOut, spareOdOut, spareOdOe, memProgSupply, memCommit, er;
  int failCount, cmpCount, cyc;
  protect_if link();
  protect_host u_protect_host (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  protect_device #(.RESET_HOLD(8)) u_protect_device (
    .mclk(mclk), .reset(reset), .link(link), .cellHigh(cellHigh), .cellRecovered(cellRecovered),
    .cellLow(cellLow), .sampling(sampling), .overloadTrip(overloadTrip), .shortTrip(shortTrip),
    .tempBelowRef(tempBelowRef), .supplyLow(supplyLow), .railGood(railGood), .packZero(packZero),
    .startupDetect(startupDetect), .bypassCell(bypassCell), .chargeFetOn(chargeFetOn),
    .dischargeFetOn(dischargeFetOn), .thermistorBiasOut(thermistorBiasOut), .spareOdOut(spareOdOut),
    .spareOdOe(spareOdOe), .memProgSupply(memProgSupply), .memCommit(memCommit));
  protect_chk #(.RESET_HOLD(8)) u_protect_chk (.mclk(mclk), .reset(reset), .hostMode(link.hostMode),
    .shutdownRequest(link.shutdownRequest), .biasEnable(link.biasEnable), .spareEnable(link.spareEnable),
    .zeroVoltCharge(link.zeroVoltCharge), .bypassSelect(link.bypassSelect), .faultAlertN(link.faultAlertN),
    .hostResetN(link.hostResetN), .bypassCell(bypassCell), .chargeFetOn(chargeFetOn),
    .dischargeFetOn(dischargeFetOn), .thermistorBiasOut(thermistorBiasOut), .spareOdOe(spareOdOe),
    .sampling(sampling), .overloadTrip(overloadTrip), .shortTrip(shortTrip), .tempBelowRef(tempBelowRef),
    .supplyLow(supplyLow), .railGood(railGood));
  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      failCount++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tallyAndFinish();
    $display("compares %0d mismatches %0d", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Outputs are compared mid-cycle, after the registered updates have landed
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      failCount++;
      tallyAndFinish();
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, cellHigh, cellRecovered, cellLow} = '0;
    {sampling, overloadTrip, shortTrip, tempBelowRef, supplyLow, packZero, startupDetect} = '0;
    railGood = 1;
    reset = 1;
    void'($urandom(56));
    repeat (20) @(posedge mclk);
    reset <= 0;
    wt(4); chk(link.hostResetN, 0);
    wt(8); chk(link.hostResetN, 1);
    @(posedge mclk); supplyLow <= 1;
    wt(2); chk(link.hostResetN, 0);
    @(posedge mclk); supplyLow <= 0; railGood <= 0;
    // Long enough that ignoring the bad rail would already have released reset
    wt(12);
    chk(link.hostResetN, 0);
    @(posedge mclk); railGood <= 1;
    wt(12);
    apb(0, 8'h10, 32'h0);
    chk(er, 1);
    chk(rd, 0);
    apb(1, REG_CONTROL, 32'h61);
    repeat (4) begin
      b = 10'($urandom);
      b = b & ~(b >> 1);
      apb(1, REG_BYPASS, {22'h0, b});
      wt(3); chk(bypassCell, b);
    end
    @(posedge mclk); sampling <= 1;
    wt(3); chk(bypassCell, 0);
    @(posedge mclk); sampling <= 0;
    for (int i = 1; i >= 0; i--) begin
      apb(1, REG_CONTROL, i ? 32'h79 : 32'h61);
      wt(3); chk({thermistorBiasOut, spareOdOe, chargeFetOn}, {i[0], !i[0], 1'b1});
    end
    @(posedge mclk); overloadTrip <= 1;
    wt(3); chk(link.faultAlertN, 0);
    @(posedge mclk); overloadTrip <= 0; cellHigh <= 10'h001;
    apb(1, REG_CONTROL, 32'h65); apb(1, REG_CONTROL, 32'h61);
    wt(3); apb(0, REG_STATUS, 0); chk(rd[1], 1);
    @(posedge mclk); cellHigh <= 0;
    apb(1, REG_CONTROL, 32'h65); apb(1, REG_CONTROL, 32'h61);
    wt(3); chk(link.faultAlertN, 0);
    apb(0, REG_STATUS, 0); chk(rd[2:1], 0);
    wt(3); chk(link.faultAlertN, 1);
    @(posedge mclk); tempBelowRef <= 1;
    wt(3); chk({chargeFetOn, dischargeFetOn}, 0);
    apb(0, REG_STATUS, 0); chk(rd[4], 1);
    @(posedge mclk); tempBelowRef <= 0;
    apb(1, REG_MEMDATA, 32'he2); apb(1, REG_CONTROL, 32'h161);
    wt(3); chk({memProgSupply, memCommit}, 2'b11);
    apb(1, REG_CONTROL, 32'h80);
    // No depleted cell yet, so the precharge drive stays off
    wt(3);
    chk(spareOdOe, 1);
    @(posedge mclk); cellHigh <= 10'h0c4;
    wt(3); chk({bypassCell, chargeFetOn}, {10'h084, 1'b0});
    @(posedge mclk); cellHigh <= 10'h044; cellRecovered <= 10'h080;
    wt(3); chk(bypassCell, 10'h044);
    @(posedge mclk); cellHigh <= 0; cellRecovered <= '1;
    wt(3); chk({bypassCell, chargeFetOn, link.faultAlertN}, {10'h0, 2'b11});
    apb(1, REG_CONTROL, 32'h6b);
    wt(3); chk(dischargeFetOn, 0);
    @(posedge mclk); packZero <= 1;
    wt(3); chk({chargeFetOn, thermistorBiasOut, link.hostResetN}, 0);
    apb(1, REG_CONTROL, 32'h61);
    @(posedge mclk); packZero <= 0; startupDetect <= 1;
    wt(3);
    @(posedge mclk);
    startupDetect <= 0;
    wt(14); chk(link.hostResetN, 1);
    apb(1, REG_CONTROL, 32'h80);
    @(posedge mclk);
    cellLow <= 10'h010;
    wt(3);
    chk({spareOdOut, spareOdOe, dischargeFetOn}, 3'b000);
    tallyAndFinish();
  end
endmodule // testbench
